// ==== design/tcs_pkg.sv ====
// Shared constants, types and helpers of the timer/counter with shared prescaler
package tcs_pkg;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [9:0] IDX_COUNT = 10'h001;
  localparam logic [9:0] IDX_INTCTL = 10'h00B;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_CORE = 10'h090;

  // ----------------------------------------
  // Reset values and counter limits
  // ----------------------------------------
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] PSC_ZERO = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OPT_SRC_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_RATIO_MSB = 2;
  localparam int INT_FLAG_BIT = 2;
  localparam int INT_EN_BIT = 5;
  localparam int CORE_SLEEP_BIT = 0;
  localparam int CORE_WDTCLR_BIT = 1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] INHIBIT_NONE = 2'h0;

  typedef enum logic [0:0] {
    TCS_APB_IDLE = 1'b0,
    TCS_APB_ANSWER = 1'b1
  } tcs_apb_st_t;

  function automatic logic [9:0] reg_index(input logic [11:0] addr);
    reg_index = addr[11:2];
  endfunction

  // Tap n of the prescaler divides its count enable by 2^(n+1)
  function automatic logic f_tap(input logic [7:0] cnt, input logic [2:0] ratio);
    f_tap = cnt[ratio];
  endfunction

endpackage

// ==== design/tcs_prescaler.sv ====
// Eight-bit prescaler counter shared by the timer and the watchdog
`timescale 1ns/100ps
module tcs_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic count_en,
  output logic [7:0] cnt
);

  // Clear wins over counting so a write never leaves a partial count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= tcs_pkg::PSC_ZERO;
    end else if (clear) begin
      cnt <= tcs_pkg::PSC_ZERO;
    end else if (count_en) begin
      cnt <= cnt + 8'h01;
    end
  end

endmodule

// ==== design/tcs_timer.sv ====
// Timer/counter top with APB registers, shared prescaler and overflow flag
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Source select clear: count every instruction cycle, or prescaler output.
// - After a count write, no increment for two instruction cycles.
// - Source select set: count edges of the external count input.
// - Edge select clear means rising edges, set means falling edges.
// - Prescaler belongs to timer or watchdog only; assign clear gives timer.
// - Timer ratios span 1:2 to 1:256 in powers of two.
// - Prescaler count is neither readable nor writable by software.
// - Rollover from FF to 00 sets the overflow flag.
// - Interrupt request masked when enable is clear; flag still sets.
// - Timer halts during sleep; no overflow wake-up.
// - External path sampled at phases two and four of each cycle.
// - Prescaler divides the external input ahead of the sampling stage.
// - External edge reaches the counter three to seven clock periods later.
// - Prescaler is eight bits; with the watchdog it postscales timeouts.
// - Any count write clears the prescaler while the timer owns it.
// - Watchdog clear clears the prescaler while the watchdog owns it.
// - Assignment may change at any time without stop or reset.
module tcs_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic wdt_tick,
  output logic wdt_timeout,
  output logic wdt_clear,
  output logic overflow_irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  tcs_pkg::tcs_apb_st_t apb_st_reg;
  tcs_pkg::tcs_apb_st_t apb_st_next;
  logic [7:0] count_reg;
  logic [7:0] intctl_reg;
  logic [7:0] option_reg;
  logic sleep_reg;
  logic [1:0] phase_reg;
  logic [1:0] inhibit_reg;
  logic tap_prev_reg;
  logic ext_prev_reg;
  logic samp_a_reg;
  logic samp_b_reg;
  logic samp_c_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic wdt_timeout_reg;
  logic wdt_clear_reg;
  logic irq_reg;
  logic [7:0] psc_cnt;
  logic [9:0] idx;
  logic hit;
  logic setup;
  logic wr_fire;
  logic wr_count;
  logic wr_intctl;
  logic wr_option;
  logic wr_core;
  logic wdt_clr_cmd;
  logic inst_tick;
  logic q2;
  logic q4;
  logic src_counter;
  logic edge_fall;
  logic to_wdt;
  logic [2:0] ratio;
  logic ext_level;
  logic ext_rise;
  logic tap;
  logic tap_rise;
  logic sync_rise;
  logic psc_en;
  logic psc_clear;
  logic inc_src;
  logic inc;

  // ----------------------------------------
  // Option fields
  // ----------------------------------------
  assign src_counter = option_reg[tcs_pkg::OPT_SRC_BIT];
  assign edge_fall = option_reg[tcs_pkg::OPT_EDGE_BIT];
  assign to_wdt = option_reg[tcs_pkg::OPT_ASSIGN_BIT];
  assign ratio = option_reg[tcs_pkg::OPT_RATIO_MSB:tcs_pkg::OPT_RATIO_LSB];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign idx = tcs_pkg::reg_index(paddr);
  assign hit = (paddr[1:0] == 2'h0) &&
               ((idx == tcs_pkg::IDX_COUNT) || (idx == tcs_pkg::IDX_INTCTL) ||
                (idx == tcs_pkg::IDX_OPTION) || (idx == tcs_pkg::IDX_CORE));
  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pready_reg && pwrite && hit;
  assign wr_count = wr_fire && (idx == tcs_pkg::IDX_COUNT);
  assign wr_intctl = wr_fire && (idx == tcs_pkg::IDX_INTCTL);
  assign wr_option = wr_fire && (idx == tcs_pkg::IDX_OPTION);
  assign wr_core = wr_fire && (idx == tcs_pkg::IDX_CORE);
  assign wdt_clr_cmd = wr_core && pwdata[tcs_pkg::CORE_WDTCLR_BIT];

  always_comb begin
    apb_st_next = apb_st_reg;
    case (apb_st_reg)
      tcs_pkg::TCS_APB_IDLE: begin
        if (setup) begin
          apb_st_next = tcs_pkg::TCS_APB_ANSWER;
        end
      end
      tcs_pkg::TCS_APB_ANSWER: begin
        apb_st_next = tcs_pkg::TCS_APB_IDLE;
      end
      default: begin
        apb_st_next = tcs_pkg::TCS_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st_reg <= tcs_pkg::TCS_APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      apb_st_reg <= apb_st_next;
      pready_reg <= (apb_st_next == tcs_pkg::TCS_APB_ANSWER);
      pslverr_reg <= (apb_st_next == tcs_pkg::TCS_APB_ANSWER) && !hit;
    end
  end

  // Read data is registered in the setup cycle; prescaler is not visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= 32'h0000_0000;
      if (!pwrite && hit) begin
        case (idx)
          tcs_pkg::IDX_COUNT: prdata_reg[7:0] <= count_reg;
          tcs_pkg::IDX_INTCTL: prdata_reg[7:0] <= intctl_reg;
          tcs_pkg::IDX_OPTION: prdata_reg[7:0] <= option_reg;
          tcs_pkg::IDX_CORE: prdata_reg[tcs_pkg::CORE_SLEEP_BIT] <= sleep_reg;
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Assignment may be rewritten any time; no side effect on the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_reg <= tcs_pkg::OPTION_RESET;
    end else if (wr_option) begin
      option_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
    end else if (wr_core) begin
      sleep_reg <= pwdata[tcs_pkg::CORE_SLEEP_BIT];
    end
  end

  // Overflow sets the flag even if the same write clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_reg <= tcs_pkg::INTCTL_RESET;
    end else begin
      if (wr_intctl) begin
        intctl_reg <= pwdata[7:0];
      end
      if (inc && !wr_count && (count_reg == tcs_pkg::COUNT_MAX)) begin
        intctl_reg[tcs_pkg::INT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Request only, the flag stays set until software writes it clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= intctl_reg[tcs_pkg::INT_FLAG_BIT] && intctl_reg[tcs_pkg::INT_EN_BIT];
    end
  end

  // ----------------------------------------
  // Phase clocks: four pclk periods per instruction cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= tcs_pkg::PHASE_Q1;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign q2 = (phase_reg == tcs_pkg::PHASE_Q2);
  assign q4 = (phase_reg == tcs_pkg::PHASE_Q4);
  assign inst_tick = q4;

  // ----------------------------------------
  // Shared prescaler
  // ----------------------------------------
  // Edge select flips the input so the active edge is always a rise
  assign ext_level = external_count_input ^ edge_fall;
  assign ext_rise = ext_level && !ext_prev_reg;

  // Timer counting halts in sleep; the watchdog side keeps running
  always_comb begin
    if (to_wdt) begin
      psc_en = wdt_tick;
    end else if (sleep_reg) begin
      psc_en = 1'b0;
    end else if (src_counter) begin
      psc_en = ext_rise;
    end else begin
      psc_en = inst_tick;
    end
  end

  assign psc_clear = (wr_count && !to_wdt) || (wdt_clr_cmd && to_wdt);

  tcs_prescaler i_tcs_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(psc_clear),
    .count_en(psc_en),
    .cnt(psc_cnt)
  );

  // Tap bit gives 1:2 for code zero up to 1:256 for code seven
  assign tap = tcs_pkg::f_tap(psc_cnt, ratio);
  assign tap_rise = tap && !tap_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_prev_reg <= 1'b0;
      // High matches an idle low pin under the reset falling-edge choice
      ext_prev_reg <= 1'b1;
    end else begin
      tap_prev_reg <= tap;
      ext_prev_reg <= ext_level;
    end
  end

  // ----------------------------------------
  // External path sampling on phases two and four
  // ----------------------------------------
  // Prescaled tap when owned by the timer, else the edge-adjusted pin
  assign inc_src = to_wdt ? ext_level : tap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // No false edge right after reset with the pin idle low
      samp_a_reg <= 1'b1;
      samp_b_reg <= 1'b1;
      samp_c_reg <= 1'b1;
    end else begin
      if (q2) begin
        samp_a_reg <= inc_src;
      end
      if (q4) begin
        samp_b_reg <= samp_a_reg;
        samp_c_reg <= samp_b_reg;
      end
    end
  end

  // One pulse in the cycle after phase four, giving the bounded latency
  assign sync_rise = (phase_reg == tcs_pkg::PHASE_Q1) && samp_b_reg && !samp_c_reg;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb begin
    if (sleep_reg || (inhibit_reg != tcs_pkg::INHIBIT_NONE)) begin
      inc = 1'b0;
    end else if (src_counter) begin
      inc = sync_rise;
    end else if (to_wdt) begin
      inc = inst_tick;
    end else begin
      inc = tap_rise;
    end
  end

  // Inhibit counts down on instruction cycles after any count write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_reg <= tcs_pkg::INHIBIT_NONE;
    end else if (wr_count) begin
      inhibit_reg <= tcs_pkg::INHIBIT_CYCLES;
    end else if (inst_tick && (inhibit_reg != tcs_pkg::INHIBIT_NONE)) begin
      inhibit_reg <= inhibit_reg - 2'h1;
    end
  end

  // Wraps from FF to 00 and keeps going, flag or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= tcs_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_reg <= pwdata[7:0];
    end else if (inc) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Watchdog side
  // ----------------------------------------
  // Postscaled timeout when assigned, raw timeout otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_timeout_reg <= 1'b0;
      wdt_clear_reg <= 1'b0;
    end else begin
      wdt_timeout_reg <= to_wdt ? tap_rise : wdt_tick;
      wdt_clear_reg <= wdt_clr_cmd;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign wdt_timeout = wdt_timeout_reg;
  assign wdt_clear = wdt_clear_reg;
  assign overflow_irq = irq_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wrap;
    inc && (count_reg == tcs_pkg::COUNT_MAX) && !wr_count;
  endsequence

  sequence s_count_write;
    wr_count && !sleep_reg;
  endsequence

  property p_wrap;
    s_wrap |=> (count_reg == tcs_pkg::COUNT_ZERO) && intctl_reg[tcs_pkg::INT_FLAG_BIT];
  endproperty
  a_wrap: assert property (p_wrap) else $error("rollover did not wrap and set flag");

  property p_write_inhibit;
    s_count_write |=> (count_reg == $past(pwdata[7:0])) ##1 $stable(count_reg) [*4];
  endproperty
  a_write_inhibit: assert property (p_write_inhibit) else $error("count moved during inhibit");

  property p_sleep_hold;
    sleep_reg && !wr_count |=> count_reg == $past(count_reg);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  property p_psc_clr_timer;
    wr_count && !to_wdt |=> psc_cnt == tcs_pkg::PSC_ZERO;
  endproperty
  a_psc_clr_timer: assert property (p_psc_clr_timer) else $error("count write kept prescaler");

  property p_psc_clr_wdt;
    wdt_clr_cmd && to_wdt |=> (psc_cnt == tcs_pkg::PSC_ZERO) && wdt_clear;
  endproperty
  a_psc_clr_wdt: assert property (p_psc_clr_wdt) else $error("watchdog clear kept prescaler");

  property p_irq_mask;
    !intctl_reg[tcs_pkg::INT_EN_BIT] |=> !overflow_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request raised");

  property p_flag_sticky;
    intctl_reg[tcs_pkg::INT_FLAG_BIT] && !wr_intctl |=> intctl_reg[tcs_pkg::INT_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

  property p_timer_plain;
    !src_counter && to_wdt && !sleep_reg && inhibit_reg == tcs_pkg::INHIBIT_NONE && inst_tick && !wr_count
      |=> count_reg == $past(count_reg) + 8'h01;
  endproperty
  a_timer_plain: assert property (p_timer_plain) else $error("no step on instruction cycle");

  property p_apb_answer;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bus answer not one cycle after setup");

endmodule

// ==== tb/tcs_count_src.sv ====
// External count source model that drives the count pin
`timescale 1ns/100ps
module tcs_count_src (
  input wire logic pclk,
  output logic pin
);
  initial pin = 1'b0;

  // Equal high and low widths of eight cycles or more keep each level visible to the sampler
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      pin <= 1'b1;
      repeat (w) @(posedge pclk);
      pin <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask
endmodule

// ==== tb/tcs_timer_tb.sv ====
// Self-checking bench for the timer/counter with shared prescaler
`timescale 1ns/100ps
module tcs_timer_tb;
  localparam logic [11:0] A_CNT = 12'h004;
  localparam logic [11:0] A_INT = 12'h02C;
  localparam logic [11:0] A_OPT = 12'h204;
  localparam logic [11:0] A_CORE = 12'h240;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
  logic ext_in, wdt_tick, wdt_timeout, wdt_clear, overflow_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v1;
  logic [7:0] c_opt [4] = '{8'h28, 8'h38, 8'h20, 8'h21};
  int c_np [4] = '{5, 3, 8, 8};
  int c_exp [4] = '{5, 3, 4, 2};
  int err_total, n_compared, k;
  int n_tmo = 0;
  int n_clr = 0;

  tcs_timer i_tcs_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(ext_in), .wdt_tick(wdt_tick), .wdt_timeout(wdt_timeout),
    .wdt_clear(wdt_clear), .overflow_irq(overflow_irq));
  tcs_count_src i_tcs_count_src (.pclk(pclk), .pin(ext_in));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (wdt_timeout === 1'b1) n_tmo <= n_tmo + 1;
    if (wdt_clear === 1'b1) n_clr <= n_clr + 1;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Idle cycle after each transfer so psel is never driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, rd);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, rd);
    chk(nm, e, rd);
  endtask

  task automatic rd_rng(input string nm, input logic [11:0] a, input int lo, input int hi);
    apb(1'b0, a, 32'h00000000, rd);
    n_compared++;
    if ($isunknown(rd) || rd < lo || rd > hi) begin
      err_total++;
      $display("unexpected %s: expected %0d..%0d, seen %h", nm, lo, hi, rd);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      wdt_tick <= 1'b1;
      @(posedge pclk);
      wdt_tick <= 1'b0;
      cyc(3);
    end
  endtask

  // Watchdog sized well above the roughly 9000 cycles of the sequence
  initial begin
    cyc(40000);
    err_total++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, wdt_tick} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {err_total, n_compared} = {32'd0, 32'd0};
    cyc(6);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("count_value", A_CNT, 32'h00000000);
    rd_chk("interrupt_control", A_INT, 32'h00000000);
    wr(12'h100, 8'h55);
    chk("slverr", 32'h00000001, {31'h0, err_seen});
    rd_chk("unaligned", 12'h205, 32'h00000000);
    chk("slverr", 32'h00000001, {31'h0, err_seen});
    rd_chk("option_config", A_OPT, 32'h000000FF);
    chk("slverr", 32'h00000000, {31'h0, err_seen});
    wr(A_OPT, 8'h08);
    wr(A_CNT, 8'h00);
    cyc(40);
    rd_rng("inhibited count", A_CNT, 8, 9);
    apb(1'b0, A_CNT, 32'h00000000, v1);
    cyc(37);
    rd_chk("timer rate", A_CNT, v1 + 32'd10);
    wr(A_CORE, 8'h02);
    for (int r = 0; r < 8; r++) begin
      wr(A_OPT, 8'(r));
      wr(A_CNT, 8'h00);
      cyc(12);
      apb(1'b0, A_CNT, 32'h00000000, v1);
      cyc((8 << r) * 3 - 3);
      rd_chk("scaled rate", A_CNT, v1 + 32'd3);
    end
    // Each gap is under half a 1:256 period; an uncleared scaler would step in one of them
    repeat (3) begin
      wr(A_CNT, 8'h00);
      cyc(440);
      rd_chk("scaler cleared", A_CNT, 32'h00000000);
    end
    wr(A_CNT, 8'hFC);
    wr(A_CORE, 8'h02);
    wr(A_OPT, 8'h08);
    wr(A_INT, 8'h00);
    cyc(60);
    rd_chk("flag set", A_INT, 32'h00000004);
    chk("irq masked", 32'h00000000, {31'h0, overflow_irq});
    rd_rng("after rollover", A_CNT, 10, 13);
    wr(A_INT, 8'h24);
    cyc(1);
    chk("irq", 32'h00000001, {31'h0, overflow_irq});
    rd_chk("flag kept", A_INT, 32'h00000024);
    wr(A_INT, 8'h20);
    cyc(1);
    chk("irq cleared", 32'h00000000, {31'h0, overflow_irq});
    wr(A_INT, 8'h00);
    wr(A_CORE, 8'h01);
    cyc(4);
    apb(1'b0, A_CNT, 32'h00000000, v1);
    cyc(100);
    rd_chk("sleep hold", A_CNT, v1);
    wr(A_CORE, 8'h00);
    // Prompt and slow pulse widths; count written well after the edge mode changes
    for (int i = 0; i < 4; i++) begin
      wr(A_CORE, 8'h02);
      wr(A_OPT, c_opt[i]);
      cyc(12);
      wr(A_CNT, 8'h00);
      cyc(12);
      i_tcs_count_src.pulses(c_np[i], 8 + 4 * i);
      cyc(12);
      rd_chk("edge count", A_CNT, 32'(c_exp[i]));
    end
    wr(A_CNT, 8'h00);
    k = n_clr;
    wr(A_CORE, 8'h02);
    cyc(1);
    chk("wdt clear pulse", 32'(k + 1), 32'(n_clr));
    wr(A_OPT, 8'h0A);
    k = n_tmo;
    ticks(3);
    wr(A_CORE, 8'h02);
    ticks(3);
    chk("postscale cleared", 32'(k), 32'(n_tmo));
    ticks(8);
    chk("postscale 1:8", 32'(k + 1), 32'(n_tmo));
    wr(A_CORE, 8'h02);
    wr(A_OPT, 8'h00);
    k = n_tmo;
    ticks(3);
    chk("wdt unscaled", 32'(k + 3), 32'(n_tmo));
    complete_run();
  end
endmodule
